// ===== logic/tcws_pkg.sv
// shared constants for the two-wire configuration link
package tcws_pkg;
    // bus address: six fixed upper bits, lowest bit from the strap pin
    localparam logic [5:0] ADDR_UPPER = 6'h26;
    localparam logic [6:0] DEV_ADDR_BASE = {ADDR_UPPER, 1'b0};
    // direction bit values
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // register file geometry and named registers
    localparam int PTR_W = 8;
    localparam int REG_COUNT = 256;
    localparam logic [7:0] REG_DPLL_VIDEO_TUNING = 8'h1c;
    localparam logic [7:0] REG_DC_RESTORE_CONTROL = 8'h23;
    localparam logic [7:0] REG_POWER_CONTROL = 8'h1b;
    localparam logic [7:0] STANDBY_CODE = 8'h0f;
    localparam logic [7:0] DEFAULT_REG_VALUE = 8'h00;
    // recommended start-up values
    localparam logic [7:0] TUNING_RECOMMENDED = 8'h49;
    localparam logic [7:0] DC_RESTORE_RECOMMENDED = 8'h78;
    // serial clock deglitch depth in reference clock periods
    localparam int DGL_STAGES = 3;
    // host serial clock timing, one quarter of a bit time
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCL_QUARTER_NS = 1000;
    localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ===== logic/tcws_if.sv
// two-wire bus wires shared by the host end and the device end
interface tcws_if;
    logic host_scl_o; // host clock output level
    logic host_scl_oe; // host drives the clock line
    logic host_sda_o; // host data output level
    logic host_sda_oe; // host drives the data line
    logic dev_sda_o; // device data output level
    logic dev_sda_oe; // device drives the data line
    wire scl_line; // resolved clock line, pulled up
    wire sda_line; // resolved data line, pulled up

    // wired-and with a pull-up: any enabled low driver wins
    assign scl_line = ~(host_scl_oe & ~host_scl_o);
    assign sda_line = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe,
                  input scl_line, input sda_line);
    modport device (output dev_sda_o, output dev_sda_oe, input scl_line, input sda_line);
endinterface

// ===== logic/tcws_deglitch.sv
// two-flop synchroniser followed by an agreement filter
module tcws_deglitch #(
    parameter int STAGES = tcws_pkg::DGL_STAGES,
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    import tcws_pkg::*;

    logic sync1_q; // first synchroniser stage, read only by sync2_q
    logic sync2_q; // second synchroniser stage
    logic [STAGES-1:0] hist_q; // recent settled samples
    logic all_high; // every sample agrees high
    logic all_low; // every sample agrees low

    assign all_high = &hist_q;
    assign all_low = ~|hist_q;

    // output moves only after STAGES agreeing samples, so short spikes never reach it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= RESET_VAL;
            sync2_q <= RESET_VAL;
            hist_q <= {STAGES{RESET_VAL}};
            dout <= RESET_VAL;
        end else begin
            sync1_q <= din;
            sync2_q <= sync1_q;
            hist_q <= {hist_q[STAGES-2:0], sync2_q};
            if (all_high) begin
                dout <= 1'b1;
            end else if (all_low) begin
                dout <= 1'b0;
            end
        end
    end
endmodule // tcws_deglitch

// ===== logic/tcws_slave.sv
// device end: two-wire configuration slave on the reference crystal clock
// Behaviour
// - address is fixed six bits plus strap bit
// - answer 0x4c strap low, 0x4d strap high
// - host opens each transfer with start condition
// - watch lines, ignore everything before a start
// - direction bit: one reads, zero writes
// - matching address is acknowledged by pulling data low
// - transfer ends at stop or repeated start
// - first write byte loads pointer, rest stored
// - pointer advances after each written byte
// - pointer advances after each read byte
// - read: set pointer, repeated start, read bytes
// - clock deglitched three periods, write data on rise
// - read data changes after delayed falling edge
// - host holds data stable while clock high
// - data line is open drain only
// - power-on and reset pin restore register defaults
// - defaults select ac rgb, first channel, 24 bits
// - host writes 0x49 to tuning after reset
// - host writes 0x78 to dc restore after reset
// - serial link keeps working in standby
module tcws_slave #(
    parameter logic [7:0] DEFAULT_VALUE = tcws_pkg::DEFAULT_REG_VALUE
) (
    input wire logic xtal_clk,
    input wire logic rst,
    tcws_if.device bus,
    input wire logic addr_strap,
    input wire logic reset_pin_n,
    output logic [7:0] tuning_o,
    output logic [7:0] dc_restore_o,
    output logic standby_o
);
    import tcws_pkg::*;

    typedef enum logic [2:0] {st_idle, st_recv, st_ack, st_send, st_rack} tcws_sstate_t;
    typedef enum logic [1:0] {k_addr, k_ptr, k_data} tcws_kind_t;

    logic scl_f; // filtered, delayed clock line
    logic sda_f; // data line with the same delay, keeps start and stop ordering
    logic strap_f; // settled strap level
    logic reset_pin_f; // settled reset pin, low resets
    logic scl_p_q; // filtered clock one cycle ago
    logic sda_p_q; // filtered data one cycle ago
    logic scl_rise; // delayed rising clock edge
    logic scl_fall; // delayed falling clock edge
    logic start_cond; // data falls while clock high
    logic stop_cond; // data rises while clock high
    logic [6:0] own_addr; // address this device answers to
    logic [7:0] rd_byte; // register under the pointer
    logic [7:0] regs_q [REG_COUNT]; // configuration registers
    tcws_sstate_t state_q, state_d; // byte engine state
    tcws_kind_t kind_q, kind_d; // what the byte being received means
    logic [3:0] cnt_q, cnt_d; // bits seen in the current byte
    logic [7:0] shift_q, shift_d; // receive or transmit shifter
    logic [PTR_W-1:0] ptr_q, ptr_d; // register pointer
    logic rw_q, rw_d; // latched direction bit
    logic sda_low_q, sda_low_d; // pull the data line low
    logic nack_q, nack_d; // host did not acknowledge a read byte
    logic wr_en; // store shift_q at the pointer
    logic standby_q; // power control holds the standby code

    // both lines share one delay, so their relative order survives the filter
    tcws_deglitch #(.STAGES(DGL_STAGES), .RESET_VAL(1'b1)) u_scl (
        .clk(xtal_clk), .rst(rst), .din(bus.scl_line), .dout(scl_f));
    tcws_deglitch #(.STAGES(DGL_STAGES), .RESET_VAL(1'b1)) u_sda (
        .clk(xtal_clk), .rst(rst), .din(bus.sda_line), .dout(sda_f));
    tcws_deglitch #(.STAGES(DGL_STAGES), .RESET_VAL(1'b0)) u_strap (
        .clk(xtal_clk), .rst(rst), .din(addr_strap), .dout(strap_f));
    tcws_deglitch #(.STAGES(DGL_STAGES), .RESET_VAL(1'b1)) u_rstpin (
        .clk(xtal_clk), .rst(rst), .din(reset_pin_n), .dout(reset_pin_f));

    // bus events from the delayed lines
    assign scl_rise = scl_f & ~scl_p_q;
    assign scl_fall = ~scl_f & scl_p_q;
    assign start_cond = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign stop_cond = scl_f & scl_p_q & ~sda_p_q & sda_f;
    assign own_addr = {ADDR_UPPER, strap_f};
    assign rd_byte = regs_q[ptr_q];

    // open drain: the output level is always low, only the enable moves
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = sda_low_q;

    // registers drive the tuning and dc restore outputs directly; standby goes through standby_q
    assign tuning_o = regs_q[REG_DPLL_VIDEO_TUNING];
    assign dc_restore_o = regs_q[REG_DC_RESTORE_CONTROL];
    assign standby_o = standby_q;

    // byte engine; stop and start override whatever byte is in flight
    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        sda_low_d = sda_low_q;
        nack_d = nack_q;
        wr_en = 1'b0;
        if (stop_cond) begin
            state_d = st_idle;
            sda_low_d = 1'b0;
        end else if (start_cond) begin
            // a repeated start lands here too and keeps the pointer
            state_d = st_recv;
            kind_d = k_addr;
            cnt_d = 4'h0;
            sda_low_d = 1'b0;
        end else begin
            unique case (state_q)
                st_idle: begin
                    // nothing moves until a start
                    state_d = st_idle;
                end
                st_recv: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_f};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        cnt_d = 4'h0;
                        state_d = st_ack;
                        sda_low_d = 1'b1;
                        unique case (kind_q)
                            k_addr: begin
                                if (shift_q[7:1] != own_addr) begin
                                    // not ours: stay off the line until the next start
                                    state_d = st_idle;
                                    sda_low_d = 1'b0;
                                end else begin
                                    rw_d = shift_q[0];
                                end
                            end
                            k_ptr: ptr_d = shift_q;
                            k_data: begin
                                wr_en = 1'b1;
                                ptr_d = ptr_q + 8'h01;
                            end
                            default: state_d = st_idle;
                        endcase
                    end
                end
                st_ack: begin
                    if (scl_fall) begin
                        if (kind_q == k_addr && rw_q == RW_READ) begin
                            // first read byte comes from the pointer set earlier
                            state_d = st_send;
                            shift_d = rd_byte;
                            sda_low_d = ~rd_byte[7];
                        end else begin
                            state_d = st_recv;
                            sda_low_d = 1'b0;
                            kind_d = (kind_q == k_addr) ? k_ptr : k_data;
                        end
                    end
                end
                st_send: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == BITS_PER_BYTE) begin
                            state_d = st_rack;
                            sda_low_d = 1'b0;
                            cnt_d = 4'h0;
                            ptr_d = ptr_q + 8'h01;
                        end else begin
                            sda_low_d = ~shift_q[3'h7 - cnt_q[2:0]];
                        end
                    end
                end
                st_rack: begin
                    if (scl_rise) begin
                        nack_d = sda_f;
                    end else if (scl_fall) begin
                        if (nack_q) begin
                            state_d = st_idle;
                        end else begin
                            state_d = st_send;
                            shift_d = rd_byte;
                            sda_low_d = ~rd_byte[7];
                        end
                    end
                end
                default: begin
                    state_d = st_idle;
                    sda_low_d = 1'b0;
                end
            endcase
        end
    end

    // control state; the reset pin acts like power-on reset
    always_ff @(posedge xtal_clk or posedge rst) begin
        if (rst) begin
            state_q <= st_idle;
            kind_q <= k_addr;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= RW_WRITE;
            sda_low_q <= 1'b0;
            nack_q <= 1'b0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else if (!reset_pin_f) begin
            state_q <= st_idle;
            kind_q <= k_addr;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= RW_WRITE;
            sda_low_q <= 1'b0;
            nack_q <= 1'b0;
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            sda_low_q <= sda_low_d;
            nack_q <= nack_d;
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    // register file; defaults stand for ac rgb on the first channel, 24 bit out
    always_ff @(posedge xtal_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_q[i] <= DEFAULT_VALUE;
            end
        end else if (!reset_pin_f) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_q[i] <= DEFAULT_VALUE;
            end
        end else if (wr_en) begin
            regs_q[ptr_q] <= shift_q;
        end
    end

    // standby is only reported; the serial logic is never gated by it
    always_ff @(posedge xtal_clk or posedge rst) begin
        if (rst) begin
            standby_q <= 1'b0;
        end else begin
            standby_q <= (regs_q[REG_POWER_CONTROL] == STANDBY_CODE);
        end
    end
endmodule // tcws_slave

// ===== logic/tcws_host.sv
// host end: two-wire bus master with start-up writes and a one-byte command port
module tcws_host #(
    parameter int QUARTER_CYC = tcws_pkg::SCL_QUARTER_CYC,
    parameter logic [6:0] INIT_DEV_ADDR = tcws_pkg::DEV_ADDR_BASE
) (
    input wire logic clk,
    input wire logic rst,
    tcws_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [6:0] cmd_dev_addr,
    input wire logic [7:0] cmd_reg,
    input wire logic [7:0] cmd_wdata,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic rsp_nack
);
    import tcws_pkg::*;

    typedef enum logic [1:0] {op_start, op_tx, op_rx, op_stop} tcws_op_t;

    logic sda_s1_q; // first synchroniser stage, read only by sda_s2_q
    logic sda_s2_q; // settled data line
    logic busy_q; // a sequence is running
    logic [1:0] init_q; // start-up writes finished so far
    logic init_done; // both start-up writes are out
    logic [15:0] div_q; // quarter-bit divider
    logic tick; // end of a quarter
    logic [1:0] qtr_q; // quarter within the bit
    logic [2:0] step_q; // position in the sequence
    logic [2:0] last_step; // stop step of this sequence
    logic [3:0] bit_q; // bit within byte, 8 is the acknowledge slot
    logic read_q; // latched direction of the sequence
    logic [6:0] dev_q; // latched device address
    logic [7:0] reg_q; // latched register number
    logic [7:0] wdata_q; // latched write byte
    logic [7:0] shift_q; // read shifter
    logic scl_low_q; // pull the clock low
    logic sda_low_q; // pull the data line low
    logic nack_q; // some byte went unacknowledged
    tcws_op_t op; // operation of the current step
    logic [7:0] tx_byte; // byte of the current transmit step
    logic tx_bit; // bit to place on the line

    assign init_done = init_q[1];
    assign cmd_ready = ~busy_q & init_done;
    assign tick = busy_q && (div_q == 16'(QUARTER_CYC - 1));
    assign last_step = read_q ? 3'h6 : 3'h4;
    assign tx_bit = tx_byte[3'h7 - bit_q[2:0]];

    // open drain drivers: level fixed low, enables carry the value
    assign bus.host_scl_o = 1'b0;
    assign bus.host_scl_oe = scl_low_q;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe = sda_low_q;

    // sequence table; a read reverses direction with a repeated start
    always_comb begin
        op = op_stop;
        tx_byte = 8'h00;
        unique case ({read_q, step_q})
            4'h0, 4'h8, 4'hb: op = op_start;
            4'h1, 4'h9: begin
                op = op_tx;
                tx_byte = {dev_q, RW_WRITE};
            end
            4'h2, 4'ha: begin
                op = op_tx;
                tx_byte = reg_q;
            end
            4'h3: begin
                op = op_tx;
                tx_byte = wdata_q;
            end
            4'hc: begin
                op = op_tx;
                tx_byte = {dev_q, RW_READ};
            end
            4'hd: op = op_rx;
            default: op = op_stop;
        endcase
    end

    // data line synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            sda_s1_q <= bus.sda_line;
            sda_s2_q <= sda_s1_q;
        end
    end

    // bit engine: clock low in quarters 0-1, high in 2-3; data bits move only in quarter 0, start and stop edges in quarter 2
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            init_q <= 2'h0;
            div_q <= 16'h0000;
            qtr_q <= 2'h0;
            step_q <= 3'h0;
            bit_q <= 4'h0;
            read_q <= 1'b0;
            dev_q <= 7'h00;
            reg_q <= 8'h00;
            wdata_q <= 8'h00;
            shift_q <= 8'h00;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            nack_q <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
            rsp_nack <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (!busy_q) begin
                div_q <= 16'h0000;
                qtr_q <= 2'h0;
                step_q <= 3'h0;
                bit_q <= 4'h0;
                nack_q <= 1'b0;
                if (!init_done) begin
                    // start-up writes: tuning first, then dc restore
                    busy_q <= 1'b1;
                    scl_low_q <= 1'b1;
                    read_q <= RW_WRITE;
                    dev_q <= INIT_DEV_ADDR;
                    reg_q <= init_q[0] ? REG_DC_RESTORE_CONTROL : REG_DPLL_VIDEO_TUNING;
                    wdata_q <= init_q[0] ? DC_RESTORE_RECOMMENDED : TUNING_RECOMMENDED;
                end else if (cmd_valid) begin
                    busy_q <= 1'b1;
                    scl_low_q <= 1'b1;
                    read_q <= cmd_read;
                    dev_q <= cmd_dev_addr;
                    reg_q <= cmd_reg;
                    wdata_q <= cmd_wdata;
                end
            end else if (!tick) begin
                div_q <= div_q + 16'h0001;
            end else begin
                div_q <= 16'h0000;
                qtr_q <= qtr_q + 2'h1;
                unique case (qtr_q)
                    2'h0: begin
                        // clock is low here, so data may change
                        unique case (op)
                            op_start: sda_low_q <= 1'b0;
                            op_tx: sda_low_q <= (bit_q == BITS_PER_BYTE) ? 1'b0 : ~tx_bit;
                            op_rx: sda_low_q <= 1'b0;
                            op_stop: sda_low_q <= 1'b1;
                        endcase
                    end
                    2'h1: scl_low_q <= 1'b0;
                    2'h2: begin
                        if (op == op_start) begin
                            sda_low_q <= 1'b1;
                        end else if (op == op_stop) begin
                            sda_low_q <= 1'b0;
                        end else if (op == op_tx && bit_q == BITS_PER_BYTE) begin
                            nack_q <= nack_q | sda_s2_q;
                        end else if (op == op_rx && bit_q != BITS_PER_BYTE) begin
                            shift_q <= {shift_q[6:0], sda_s2_q};
                        end
                    end
                    2'h3: begin
                        if (op == op_stop) begin
                            busy_q <= 1'b0;
                            rsp_valid <= init_done;
                            init_q <= init_q + {1'b0, ~init_done};
                            rsp_nack <= nack_q;
                            rsp_rdata <= shift_q;
                        end else begin
                            scl_low_q <= 1'b1;
                            if (op == op_start) begin
                                step_q <= step_q + 3'h1;
                            end else if (bit_q != BITS_PER_BYTE) begin
                                bit_q <= bit_q + 4'h1;
                            end else begin
                                bit_q <= 4'h0;
                                // an unanswered byte cuts straight to the stop
                                step_q <= (op == op_tx && (nack_q | sda_s2_q)) ? last_step : step_q + 3'h1;
                            end
                        end
                    end
                endcase
            end
        end
    end
endmodule // tcws_host

// ===== verification/tcws_link_asserts.sv
// concurrent checks on the two-wire link between the host end and the device end
module tcws_link_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl_line,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // the fast host clock oversamples the slower device flops
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // open drain: every driver only pulls low
    property p_od; !dev_sda_o && !host_sda_o && !host_scl_o; endproperty
    a_od: assert property (p_od) else $error("line driven high");
    // acknowledge is raised only while the clock is low
    property p_ack; $rose(dev_sda_oe) |-> !scl_line; endproperty
    a_ack: assert property (p_ack) else $error("ack raised with clock high");
    // read data is released only while the clock is low
    property p_rd; $fell(dev_sda_oe) |-> !scl_line; endproperty
    a_rd: assert property (p_rd) else $error("data released with clock high");
    // no device reaction before the deglitch delay has passed
    property p_dly; $changed(dev_sda_oe) |-> !$past(scl_line, 36); endproperty
    a_dly: assert property (p_dly) else $error("device reacted before delay");
    // clock low phase is longer than the deglitch window
    property p_low; $rose(scl_line) |-> !$past(scl_line, 100); endproperty
    a_low: assert property (p_low) else $error("clock low too short");
    // device stays off the line while the host leaves the bus idle
    property p_quiet; scl_line && $past(scl_line, 75) && $past(scl_line, 150) |-> !dev_sda_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("device active on idle bus");
    // a start falls from a high data line
    property p_start; $rose(host_sda_oe) && scl_line |-> $past(sda_line); endproperty
    a_start: assert property (p_start) else $error("start from low data line");
    // at a stop the device has let go, so the line rises
    property p_stop; $fell(host_sda_oe) && scl_line |-> sda_line; endproperty
    a_stop: assert property (p_stop) else $error("stop held low");
    c_ack: cover property ($rose(dev_sda_oe));
    c_start: cover property ($rose(host_sda_oe) && scl_line);
    c_stop: cover property ($fell(host_sda_oe) && scl_line);
endmodule // tcws_link_asserts

// ===== verification/two_wire_config_slave_tb.sv
// self-checking bench joining the host end and the device end
module two_wire_config_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tcws_pkg::*;
    logic clk = 1'b0, xtal_clk = 1'b0, rst = 1'b1, reset_pin_n = 1'b1, strap = 1'b0; // clocks, resets, strap
    logic cmd_valid = 1'b0, cmd_read = 1'b0; // command handshake
    logic [6:0] cmd_dev_addr = 7'h00;
    logic [7:0] cmd_reg = 8'h00, cmd_wdata = 8'h00;
    logic cmd_ready, rsp_valid, rsp_nack, standby_o;
    logic [7:0] rsp_rdata, tuning_o, dc_restore_o;
    int n_mismatch = 0, n_tests = 0;
    always #2 clk = ~clk;
    // 48 ns link clock; its rises never meet a host clock rise
    always #24 xtal_clk = ~xtal_clk;
    tcws_if bus_if ();
    // small quarter keeps the run short; the two-quarter clock low phase still exceeds the filter latency
    tcws_host #(.QUARTER_CYC(60)) tcws_host_inst (.clk(clk), .rst(rst), .bus(bus_if), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_dev_addr(cmd_dev_addr), .cmd_reg(cmd_reg),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
    tcws_slave tcws_slave_inst (.xtal_clk(xtal_clk), .rst(rst), .bus(bus_if), .addr_strap(strap),
        .reset_pin_n(reset_pin_n), .tuning_o(tuning_o), .dc_restore_o(dc_restore_o), .standby_o(standby_o));
    tcws_link_asserts tcws_link_asserts_inst (.clk(clk), .rst(rst), .host_scl_o(bus_if.host_scl_o),
        .host_scl_oe(bus_if.host_scl_oe), .host_sda_o(bus_if.host_sda_o), .host_sda_oe(bus_if.host_sda_oe),
        .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe), .scl_line(bus_if.scl_line),
        .sda_line(bus_if.sda_line));
    task automatic test_done();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // one command: hold valid until ready is sampled high, then wait for the response pulse
    task automatic cmd(input logic rd, input logic [6:0] a, input logic [7:0] r, input logic [7:0] w);
        int n;
        n = 0;
        @(posedge clk);
        #1 {cmd_valid, cmd_read, cmd_dev_addr, cmd_reg, cmd_wdata} = {1'b1, rd, a, r, w};
        while (cmd_ready !== 1'b1 && n < 50000) begin
            n++;
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 50000) begin
            n++;
            @(posedge clk);
            #1;
        end
        chk({7'h00, rsp_valid}, 8'h01);
    endtask
    // start-up writes land before the command port opens
    task automatic t_init();
        cmd(1'b1, DEV_ADDR_BASE, REG_DC_RESTORE_CONTROL, 8'h00);
        chk(tuning_o, TUNING_RECOMMENDED);
        chk(rsp_rdata, DC_RESTORE_RECOMMENDED);
    endtask
    // read back, standby, write then read of the same register
    task automatic t_rw();
        cmd(1'b1, DEV_ADDR_BASE, REG_DPLL_VIDEO_TUNING, 8'h00);
        chk(rsp_rdata, TUNING_RECOMMENDED);
        chk({7'h00, rsp_nack}, 8'h00);
        cmd(1'b0, DEV_ADDR_BASE, REG_POWER_CONTROL, STANDBY_CODE);
        chk({7'h00, standby_o}, 8'h01);
        cmd(1'b0, DEV_ADDR_BASE, REG_DC_RESTORE_CONTROL, 8'ha5);
        chk(dc_restore_o, 8'ha5);
        cmd(1'b1, DEV_ADDR_BASE, REG_DC_RESTORE_CONTROL, 8'h00);
        chk(rsp_rdata, 8'ha5);
    endtask
    // the other strap address is refused until the strap moves
    task automatic t_miss();
        cmd(1'b0, DEV_ADDR_BASE | 7'h01, REG_DC_RESTORE_CONTROL, 8'h3c);
        chk({7'h00, rsp_nack}, 8'h01);
        chk(dc_restore_o, 8'ha5);
        strap = 1'b1;
        cmd(1'b0, DEV_ADDR_BASE | 7'h01, REG_DC_RESTORE_CONTROL, 8'h3c);
        chk({7'h00, rsp_nack}, 8'h00);
        chk(dc_restore_o, 8'h3c);
    endtask
    // reset pin restores defaults and the link still answers
    task automatic t_pin();
        @(posedge xtal_clk);
        #1 reset_pin_n = 1'b0;
        repeat (8) @(posedge xtal_clk);
        #1 reset_pin_n = 1'b1;
        repeat (10) @(posedge xtal_clk);
        chk(tuning_o, DEFAULT_REG_VALUE);
        chk({7'h00, standby_o}, 8'h00);
        cmd(1'b1, DEV_ADDR_BASE | 7'h01, REG_DPLL_VIDEO_TUNING, 8'h00);
        chk(rsp_rdata, DEFAULT_REG_VALUE);
    endtask
    // reset spans ten link cycles, which also covers over a hundred host cycles
    initial begin
        repeat (10) @(posedge xtal_clk);
        #1 rst = 1'b0;
        t_init();
        t_rw();
        t_miss();
        t_pin();
        test_done();
    end
    // watchdog well beyond the expected run of about 300 us
    initial begin
        #400000;
        n_mismatch++;
        test_done();
    end
endmodule // two_wire_config_slave_tb
